// *** pcc_consts.vh ***
// Register offsets, field positions and reset values for the power and clock control block.
// Included by the block files; definitions only.
`ifndef PCC_CONSTS_VH
`define PCC_CONSTS_VH

// Printed offsets are register indices; the APB byte address is four times the index
`define PCC_IDX_SYNC_RX 10'h084
`define PCC_IDX_STARTUP 10'h085
`define PCC_IDX_SWING 10'h08D
`define PCC_IDX_OBS_PWR 10'h08F
`define PCC_IDX_CONV_PD 10'h090
`define PCC_IDX_ACLK 10'h091
`define PCC_IDX_DIV 10'h094
`define PCC_IDX_DIRECT 10'h095
`define PCC_IDX_BIAS 10'h09A

// Writable bit masks; all other bits read zero or are storage only
`define PCC_MASK_SYNC_RX 8'hFF
`define PCC_MASK_STARTUP 8'h73
`define PCC_MASK_SWING 8'h1F
`define PCC_MASK_OBS_PWR 8'h01
`define PCC_MASK_CONV_PD 8'h03
`define PCC_MASK_ACLK 8'hFF
`define PCC_MASK_DIV 8'h03
`define PCC_MASK_DIRECT 8'h01
`define PCC_MASK_BIAS 8'hFF

// Reset values
`define PCC_RST_SYNC_RX 8'h00
`define PCC_RST_STARTUP 8'h13
`define PCC_RST_SWING 8'h00
`define PCC_RST_OBS_PWR 8'h00
`define PCC_RST_CONV_PD 8'h03
`define PCC_RST_ACLK 8'h01
`define PCC_RST_DIV 8'h00
`define PCC_RST_DIRECT 8'h00
`define PCC_RST_BIAS 8'h00

// Field positions
`define PCC_BIT_SYNC_PD 0
`define PCC_LSB_START_A 4
`define PCC_MSB_START_A 6
`define PCC_BIT_START_B 1
`define PCC_BIT_START_C 0
`define PCC_BIT_OBS_OFF 0
`define PCC_BIT_CONV1 1
`define PCC_BIT_CONV0 0
`define PCC_BIT_ACLK_OFF 0
`define PCC_BIT_DIV3 1
`define PCC_BIT_DIV2 0
`define PCC_BIT_DIRECT 0
`define PCC_BIT_BIAS 7

// Swing law: base in mV, step in mV, code ranges
`define PCC_SWING_BASE_MV 12'd993
`define PCC_SWING_STEP_MV 12'd77
`define PCC_SWING_HI_REF 5'd20
`define PCC_SWING_OFFSET_MV 12'd1000
`define PCC_SWING_SPLIT 5'd10
`define PCC_SWING_LAST 5'd19

`endif

// *** pcc_swing_map.v ***
// Maps the observation clock swing code to a swing magnitude in mV and a polarity flag.
// Pure combinational; the caller registers swing_mv and invert and leaves code_valid unconnected.
`timescale 1ns/1ps
`include "pcc_consts.vh"

module pcc_swing_map (
    // Code in
    input wire [4:0] code,
    // Result
    output reg [11:0] swing_mv,
    output reg invert,
    output reg code_valid
);

    reg [11:0] step_prod;
    reg signed [13:0] signed_mv;
    reg signed [13:0] neg_mv;

    always @* begin
        step_prod = 12'h000;
        signed_mv = 14'sh0000;
        neg_mv = 14'sh0000;
        swing_mv = 12'h000;
        invert = 1'b0;
        code_valid = 1'b1;
        if (code < `PCC_SWING_SPLIT) begin
            step_prod = code * `PCC_SWING_STEP_MV;
            signed_mv = $signed({2'b00, `PCC_SWING_BASE_MV}) - $signed({2'b00, step_prod}); // [RULE5]
        end else if (code <= `PCC_SWING_LAST) begin
            step_prod = (`PCC_SWING_HI_REF - code) * `PCC_SWING_STEP_MV;
            signed_mv = $signed({2'b00, step_prod}) - $signed({2'b00, `PCC_SWING_OFFSET_MV}); // [RULE6]
        end else begin
            code_valid = 1'b0;
        end
        // A negative swing means an inverted clock at the magnitude
        if (signed_mv < 0) begin
            invert = 1'b1; // [RULE7]
            neg_mv = -signed_mv;
            swing_mv = neg_mv[11:0];
        end else begin
            swing_mv = signed_mv[11:0];
        end
    end

endmodule // pcc_swing_map

// *** pcc_power_clock_regs.v ***
// Overview of operation
// [RULE1] Sync receiver power-down bit, 1 powers receiver and sync logic down, resets 0.
// [RULE2] Software sets sync receiver power-down when link runs without SYSREF timing.
// [RULE3] Software writes startup fields a and b 1 at start, 0 when finished.
// [RULE4] Software writes startup field c 0 at start, 1 when finished.
// [RULE5] Codes 0 to 9 give swing of 993 mV minus code times 77 mV.
// [RULE6] Codes 10 to 19 give swing of (20 minus code) times 77 mV minus 1 V.
// [RULE7] Negative swing drives the observation clock inverted.
// [RULE8] Observation clock driver off bit powers the driver down, resets 0.
// [RULE9] Per-converter power-down bits, bit 1 and bit 0, both reset 1.
// [RULE10] Analog clock receiver off bit, resets 1.
// [RULE11] Divide-by-two enable halves the converter clock from the synthesizer.
// [RULE12] Divide-by-three enable divides the synthesizer output by three.
// [RULE13] Direct clock enable bypasses the synthesizer, resets 0.
// [RULE14] Bias power-down at bit 7 powers the bias generator down.
// [RULE15] Eight-bit registers; reserved read-only bits read zero; reads return fields.
//
// APB slave holding the power and clock control registers of a dual converter.
// Assumes an APB master on pclk; control outputs feed analog power and clock switches.
`timescale 1ns/1ps
`include "pcc_consts.vh"

module pcc_power_clock_regs (
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Sync receiver
    output reg sync_receiver_power_down,
    output reg sync_input_dc_couple,
    // Start-up programming
    output reg [2:0] startup_field_a,
    output reg startup_field_b,
    output reg startup_field_c,
    // Observation clock driver
    output reg [4:0] obs_clock_swing_code,
    output reg [11:0] obs_clock_swing_mv,
    output reg obs_clock_invert,
    output reg obs_clock_driver_off,
    // Converters and analog clock
    output reg converter1_power_down,
    output reg converter0_power_down,
    output reg analog_clock_rx_off,
    // Converter clock selection
    output reg synth_divide_by_two_en,
    output reg synth_divide_by_three_en,
    output reg direct_clock_enable,
    output reg [1:0] conv_clock_source,
    // Bias
    output reg bias_power_down
);

    localparam [1:0] SRC_VCO = 2'b00;
    localparam [1:0] SRC_VCO_DIV2 = 2'b01;
    localparam [1:0] SRC_VCO_DIV3 = 2'b10;
    localparam [1:0] SRC_DIRECT = 2'b11;

    reg [7:0] sync_rx_reg;
    reg [7:0] startup_reg;
    reg [7:0] swing_reg;
    reg [7:0] obs_pwr_reg;
    reg [7:0] conv_pd_reg;
    reg [7:0] aclk_reg;
    reg [7:0] div_reg;
    reg [7:0] direct_reg;
    reg [7:0] bias_reg;

    reg [7:0] rd_next;
    reg hit_next;
    reg [1:0] src_next;
    wire [9:0] idx;
    wire word_ok;
    wire setup_phase;
    wire wr_en;
    wire [11:0] swing_mv_w;
    wire invert_w;

    // Access phase answers in one cycle: pready rises the edge after the access starts
    assign setup_phase = psel && penable && !pready;
    assign idx = paddr[11:2];
    assign word_ok = (paddr[1:0] == 2'b00);
    assign wr_en = setup_phase && pwrite && hit_next && pstrb[0];

    pcc_swing_map u_swing (
        .code(swing_reg[4:0]),
        .swing_mv(swing_mv_w),
        .invert(invert_w),
        .code_valid()
    );

    // Read mux and address decode; only byte lane 0 holds data
    always @* begin
        rd_next = 8'h00;
        hit_next = word_ok;
        if (idx == `PCC_IDX_SYNC_RX) begin
            rd_next = sync_rx_reg;
        end else if (idx == `PCC_IDX_STARTUP) begin
            rd_next = startup_reg & `PCC_MASK_STARTUP; // [RULE15]
        end else if (idx == `PCC_IDX_SWING) begin
            rd_next = swing_reg & `PCC_MASK_SWING;
        end else if (idx == `PCC_IDX_OBS_PWR) begin
            rd_next = obs_pwr_reg & `PCC_MASK_OBS_PWR;
        end else if (idx == `PCC_IDX_CONV_PD) begin
            rd_next = conv_pd_reg & `PCC_MASK_CONV_PD;
        end else if (idx == `PCC_IDX_ACLK) begin
            rd_next = aclk_reg;
        end else if (idx == `PCC_IDX_DIV) begin
            rd_next = div_reg & `PCC_MASK_DIV;
        end else if (idx == `PCC_IDX_DIRECT) begin
            rd_next = direct_reg & `PCC_MASK_DIRECT;
        end else if (idx == `PCC_IDX_BIAS) begin
            rd_next = bias_reg;
        end else begin
            hit_next = 1'b0;
        end
    end

    // Register writes; read-only reserved bits are masked off so they stay zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_rx_reg <= `PCC_RST_SYNC_RX; // [RULE1]
            startup_reg <= `PCC_RST_STARTUP; // [RULE3] [RULE4]
            swing_reg <= `PCC_RST_SWING;
            obs_pwr_reg <= `PCC_RST_OBS_PWR; // [RULE8]
            conv_pd_reg <= `PCC_RST_CONV_PD; // [RULE9]
            aclk_reg <= `PCC_RST_ACLK; // [RULE10]
            div_reg <= `PCC_RST_DIV;
            direct_reg <= `PCC_RST_DIRECT; // [RULE13]
            bias_reg <= `PCC_RST_BIAS; // [RULE14]
        end else if (wr_en) begin
            if (idx == `PCC_IDX_SYNC_RX) begin
                sync_rx_reg <= pwdata[7:0] & `PCC_MASK_SYNC_RX;
            end else if (idx == `PCC_IDX_STARTUP) begin
                startup_reg <= pwdata[7:0] & `PCC_MASK_STARTUP; // [RULE15]
            end else if (idx == `PCC_IDX_SWING) begin
                swing_reg <= pwdata[7:0] & `PCC_MASK_SWING;
            end else if (idx == `PCC_IDX_OBS_PWR) begin
                obs_pwr_reg <= pwdata[7:0] & `PCC_MASK_OBS_PWR;
            end else if (idx == `PCC_IDX_CONV_PD) begin
                conv_pd_reg <= pwdata[7:0] & `PCC_MASK_CONV_PD;
            end else if (idx == `PCC_IDX_ACLK) begin
                aclk_reg <= pwdata[7:0] & `PCC_MASK_ACLK;
            end else if (idx == `PCC_IDX_DIV) begin
                div_reg <= pwdata[7:0] & `PCC_MASK_DIV;
            end else if (idx == `PCC_IDX_DIRECT) begin
                direct_reg <= pwdata[7:0] & `PCC_MASK_DIRECT;
            end else if (idx == `PCC_IDX_BIAS) begin
                bias_reg <= pwdata[7:0] & `PCC_MASK_BIAS;
            end
        end
    end

    // APB answer: access phase with one wait state, error on unmapped or misaligned address
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (setup_phase) begin
            pready <= 1'b1;
            pslverr <= !hit_next;
            prdata <= (!pwrite && hit_next) ? {24'h000000, rd_next} : 32'h0000_0000;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Converter clock source; bypass wins, then divide by three, then by two
    always @* begin
        if (direct_reg[`PCC_BIT_DIRECT]) begin
            src_next = SRC_DIRECT; // [RULE13]
        end else if (div_reg[`PCC_BIT_DIV3]) begin
            src_next = SRC_VCO_DIV3; // [RULE12]
        end else if (div_reg[`PCC_BIT_DIV2]) begin
            src_next = SRC_VCO_DIV2; // [RULE11]
        end else begin
            src_next = SRC_VCO; // [RULE11]
        end
    end

    // Control outputs are registered copies of the fields, one cycle after the write
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_receiver_power_down <= 1'b0;
            sync_input_dc_couple <= 1'b0;
            startup_field_a <= 3'h1;
            startup_field_b <= 1'b1;
            startup_field_c <= 1'b1;
            obs_clock_swing_code <= 5'h00;
            obs_clock_swing_mv <= 12'd993;
            obs_clock_invert <= 1'b0;
            obs_clock_driver_off <= 1'b0;
            converter1_power_down <= 1'b1;
            converter0_power_down <= 1'b1;
            analog_clock_rx_off <= 1'b1;
            synth_divide_by_two_en <= 1'b0;
            synth_divide_by_three_en <= 1'b0;
            direct_clock_enable <= 1'b0;
            conv_clock_source <= SRC_VCO;
            bias_power_down <= 1'b0;
        end else begin
            // Subclass 0 users are expected to set this; the block does not enforce it
            sync_receiver_power_down <= sync_rx_reg[`PCC_BIT_SYNC_PD]; // [RULE1] [RULE2]
            sync_input_dc_couple <= sync_rx_reg[6];
            startup_field_a <= startup_reg[`PCC_MSB_START_A:`PCC_LSB_START_A]; // [RULE3]
            startup_field_b <= startup_reg[`PCC_BIT_START_B]; // [RULE3]
            startup_field_c <= startup_reg[`PCC_BIT_START_C]; // [RULE4]
            obs_clock_swing_code <= swing_reg[4:0];
            obs_clock_swing_mv <= swing_mv_w; // [RULE5] [RULE6]
            obs_clock_invert <= invert_w; // [RULE7]
            obs_clock_driver_off <= obs_pwr_reg[`PCC_BIT_OBS_OFF]; // [RULE8]
            converter1_power_down <= conv_pd_reg[`PCC_BIT_CONV1]; // [RULE9]
            converter0_power_down <= conv_pd_reg[`PCC_BIT_CONV0]; // [RULE9]
            analog_clock_rx_off <= aclk_reg[`PCC_BIT_ACLK_OFF]; // [RULE10]
            synth_divide_by_two_en <= div_reg[`PCC_BIT_DIV2]; // [RULE11]
            synth_divide_by_three_en <= div_reg[`PCC_BIT_DIV3]; // [RULE12]
            direct_clock_enable <= direct_reg[`PCC_BIT_DIRECT]; // [RULE13]
            conv_clock_source <= src_next;
            bias_power_down <= bias_reg[`PCC_BIT_BIAS]; // [RULE14]
        end
    end

endmodule // pcc_power_clock_regs

// *** pcc_regs_checker.sv ***
// Checker: APB timing and control-output relations of the power and clock registers.
// Bound to pcc_power_clock_regs; sees its ports only.
`timescale 1ns/1ps
module pcc_regs_checker (
    // APB
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [3:0] pstrb,
    input logic pready,
    input logic pslverr,
    // Controls
    input logic [4:0] obs_clock_swing_code,
    input logic [11:0] obs_clock_swing_mv,
    input logic obs_clock_invert,
    input logic converter0_power_down,
    input logic bias_power_down,
    input logic direct_clock_enable,
    input logic synth_divide_by_three_en,
    input logic [1:0] conv_clock_source
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire take = psel && penable && !pready;
    wire wr = take && pwrite && pstrb[0];
    sequence wr_to(a);
        wr && paddr == a;
    endsequence
    ready_timing_a: assert property (take |=> pready)
        else $error("no answer");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready too long");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("lone error");
    misaligned_err_a: assert property (take && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("no error");
    conv0_follow_a: assert property (wr_to(12'h240) |-> ##2 converter0_power_down == $past(pwdata[0], 2))
        else $error("conv0 pd");
    bias_follow_a: assert property (wr_to(12'h268) |-> ##2 bias_power_down == $past(pwdata[7], 2))
        else $error("bias pd");
    swing_pos_a: assert property ($stable(obs_clock_swing_code) && obs_clock_swing_code < 5'h0A |->
        !obs_clock_invert && obs_clock_swing_mv == 12'd993 - 12'd77 * obs_clock_swing_code)
        else $error("swing low codes");
    swing_neg_a: assert property ($stable(obs_clock_swing_code) && obs_clock_swing_code inside {[10:19]} |->
        obs_clock_invert && obs_clock_swing_mv == 12'd1000 - (12'd20 - obs_clock_swing_code) * 12'd77)
        else $error("swing high codes");
    src_direct_a: assert property ($stable(direct_clock_enable) && direct_clock_enable |-> conv_clock_source == 2'h3)
        else $error("direct source");
    src_div3_a: assert property ($stable({direct_clock_enable, synth_divide_by_three_en}) &&
        !direct_clock_enable && synth_divide_by_three_en |-> conv_clock_source == 2'h2)
        else $error("div3 source");
endmodule // pcc_regs_checker

bind pcc_power_clock_regs pcc_regs_checker pcc_regs_checker_inst (.*);

// *** pcc_power_clock_regs_test.sv ***
// Testbench: APB reads and writes of the power and clock registers, with expected values.
// Drives the register block alone; nothing stands on the control outputs.
`timescale 1ns/1ps
module pcc_power_clock_regs_test;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, err, sync_receiver_power_down, sync_input_dc_couple;
    logic [2:0] startup_field_a;
    logic startup_field_b, startup_field_c, obs_clock_invert, obs_clock_driver_off;
    logic [4:0] obs_clock_swing_code;
    logic [11:0] obs_clock_swing_mv;
    logic converter1_power_down, converter0_power_down, analog_clock_rx_off, bias_power_down;
    logic synth_divide_by_two_en, synth_divide_by_three_en, direct_clock_enable;
    logic [1:0] conv_clock_source;
    int bad_count = 0, n_checks = 0, cyc = 0, ex;
    logic [11:0] adr [9] = '{12'h210, 12'h214, 12'h234, 12'h23C, 12'h240, 12'h244, 12'h250,
        12'h254, 12'h268};
    logic [7:0] rst [9] = '{8'h00, 8'h13, 8'h00, 8'h00, 8'h03, 8'h01, 8'h00, 8'h00, 8'h00};
    logic [7:0] msk [9] = '{8'hFF, 8'h73, 8'h1F, 8'h01, 8'h03, 8'hFF, 8'h03, 8'h01, 8'hFF};
    // One write per step, each with the control outputs expected after it
    logic [11:0] sa [10] = '{12'h210, 12'h23C, 12'h240, 12'h240, 12'h244, 12'h268, 12'h250,
        12'h250, 12'h250, 12'h254};
    logic [7:0] sd [10] = '{8'h01, 8'h01, 8'h02, 8'h01, 8'h01, 8'h80, 8'h01, 8'h02, 8'h03, 8'h01};
    logic [11:0] so [10] = '{12'h400, 12'h600, 12'h700, 12'h680, 12'h6C0, 12'h6E0, 12'h6E5,
        12'h6EA, 12'h6EE, 12'h6FF};

    pcc_power_clock_regs pcc_power_clock_regs_inst (.*);

    always #5 pclk = ~pclk;

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            tally_and_finish;
        end
    end

    function automatic logic [31:0] outs();
        return {sync_receiver_power_down, obs_clock_driver_off, converter1_power_down,
            converter0_power_down, analog_clock_rx_off, bias_power_down, direct_clock_enable,
            synth_divide_by_three_en, synth_divide_by_two_en, conv_clock_source};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Holds the request until pready is seen high at a rising edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    // Outputs land one cycle after the store, so let an edge pass first
    task automatic ochk(input logic [31:0] exp);
        @(posedge pclk);
        #1;
        chk(outs(), exp);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        ochk(32'h1C0);
        chk({startup_field_a, startup_field_b, startup_field_c}, 32'h07);
        foreach (adr[i]) begin
            xfer(1'h0, adr[i], 32'h0);
            chk(rd, {24'h0, rst[i]});
        end
        $display("reset test done");
        foreach (adr[i]) begin
            xfer(1'h1, adr[i], 32'hFFFFFFFF);
            xfer(1'h0, adr[i], 32'h0);
            chk(rd, {24'h0, msk[i]});
        end
        ochk(32'h7FF);
        chk(sync_input_dc_couple, 32'h1);
        foreach (adr[i])
            xfer(1'h1, adr[i], 32'h0);
        ochk(32'h0);
        $display("mask test done");
        foreach (sa[i]) begin
            xfer(1'h1, sa[i], {24'h0, sd[i]});
            ochk({20'h0, so[i]});
        end
        pstrb <= 4'hE;
        xfer(1'h1, 12'h254, 32'h0);
        pstrb <= 4'hF;
        ochk(32'h6FF);
        xfer(1'h1, 12'h218, 32'hFF);
        chk(err, 32'h1);
        xfer(1'h0, 12'h211, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        ochk(32'h6FF);
        $display("control test done");
        xfer(1'h1, 12'h214, 32'h12);
        #1;
        chk({startup_field_a, startup_field_b, startup_field_c}, 32'h06);
        xfer(1'h1, 12'h214, 32'h01);
        xfer(1'h0, 12'h214, 32'h0);
        chk({err, rd[25:0], startup_field_a, startup_field_b, startup_field_c}, 32'h21);
        $display("startup test done");
        for (int c = 0; c < 20; c++) begin
            xfer(1'h1, 12'h234, 32'(c));
            xfer(1'h0, 12'h234, 32'h0);
            ex = c < 10 ? 993 - 77 * c : 1000 - (20 - c) * 77;
            chk({obs_clock_swing_code, obs_clock_invert, obs_clock_swing_mv},
                {14'h0, c[4:0], c >= 10, ex[11:0]});
        end
        $display("swing test done");
        tally_and_finish;
    end
endmodule // pcc_power_clock_regs_test
